// File: design/power_clamp.sv
// Output power limiter: range limit plus overtemperature clamp
`timescale 1ns/1ps
`default_nettype none
module power_clamp (
    input  wire logic        clock,      // System clock
    input  wire logic        srst,       // Sync reset, active high
    input  wire logic        load_en,    // New power demand valid
    input  wire logic [15:0] demand,     // Requested power word
    input  wire logic        hot,        // Temperature warning level
    output logic      [15:0] power       // Applied power value
);
    // ==========================================================
    // Clamp limit
    localparam logic [15:0] LIMIT = 16'((32'(term_pkg::POWER_MAX)
        * 32'(term_pkg::CLAMP_PCT)) / 32'(term_pkg::PCT_FULL));
    logic [15:0] demand_r;
    logic [15:0] demand_nxt;
    logic [15:0] power_r;
    logic [15:0] power_nxt;
    // Out-of-range demand saturates rather than wrapping
    always_comb begin
        demand_nxt = demand_r;
        if (load_en) begin
            demand_nxt = (demand > term_pkg::POWER_MAX) ? term_pkg::POWER_MAX : demand;
        end
        power_nxt = (hot && demand_r > LIMIT) ? LIMIT : demand_r; // R3
    end
    // Registers
    always_ff @(posedge clock) begin
        if (srst) begin
            demand_r <= term_pkg::RST_ZERO;
            power_r  <= term_pkg::RST_ZERO;
        end else begin
            demand_r <= demand_nxt;
            power_r  <= power_nxt;
        end
    end
    assign power = power_r;
endmodule
`default_nettype wire

// File: design/term_pkg.sv
// Shared constants for the terminal process-image and register bank
`default_nettype none
package term_pkg;
    // ==========================================================
    // Control and status byte fields
    localparam int MODE_BIT     = 7;
    localparam int DIR_BIT      = 6;
    localparam int IDX_MSB      = 5;
    localparam int ERR_BIT      = 6;
    localparam int TEMP_BIT     = 5;
    localparam int OVL_BIT      = 4;
    localparam int OPM_MSB      = 3;
    localparam int OPM_LSB      = 1;
    localparam int SYNC_BIT     = 0;
    // ==========================================================
    // Register indices
    localparam logic [5:0] IDX_COMMAND  = 6'h07;
    localparam logic [5:0] IDX_KIND     = 6'h08;
    localparam logic [5:0] IDX_FWREV    = 6'h09;
    localparam logic [5:0] IDX_MUXSHIFT = 6'h0A;
    localparam logic [5:0] IDX_SIGCHAN  = 6'h0B;
    localparam logic [5:0] IDX_MINLEN   = 6'h0C;
    localparam logic [5:0] IDX_DSTRUCT  = 6'h0D;
    localparam logic [5:0] IDX_ALIGN    = 6'h0F;
    localparam logic [5:0] IDX_HWREV    = 6'h10;
    localparam logic [5:0] IDX_VARIANT  = 6'h1D;
    localparam logic [5:0] IDX_UNLOCK   = 6'h1F;
    localparam logic [5:0] IDX_FEATURE  = 6'h20;
    localparam logic [5:0] IDX_UOFFSET  = 6'h21;
    localparam logic [5:0] IDX_UGAIN    = 6'h22;
    localparam logic [5:0] IDX_FBTMO    = 6'h24;
    localparam logic [5:0] IDX_TMO_ON   = 6'h25;
    localparam logic [5:0] IDX_TMO_OFF  = 6'h26;
    localparam logic [5:0] IDX_DRVMODE  = 6'h27;
    localparam logic [5:0] IDX_SCPOL    = 6'h28;
    localparam logic [5:0] IDX_MAINS    = 6'h29;
    // ==========================================================
    // Reset and fixed values
    localparam logic [15:0] RST_ZERO     = 16'h0000;
    localparam logic [15:0] VAL_MUXSHIFT = 16'h0118;
    localparam logic [15:0] VAL_SIGCHAN  = 16'h0118;
    localparam logic [15:0] VAL_MINLEN   = 16'h9800;
    localparam logic [15:0] VAL_DSTRUCT  = 16'h0004;
    localparam logic [15:0] RST_ALIGN    = 16'h7F80;
    localparam logic [15:0] RST_UGAIN    = 16'h0100;
    localparam logic [15:0] RST_FBTMO    = 16'h000A;
    localparam logic [15:0] RST_TMO_ON   = 16'h3FFF;
    localparam logic [15:0] RST_SCPOL    = 16'h0001;
    localparam logic [15:0] UNLOCK_CODE  = 16'h1235;
    localparam logic [15:0] CMD_FACTORY  = 16'h7000;
    localparam logic [15:0] POWER_MAX    = 16'h7FFF;
    localparam logic [15:0] CLAMP_PCT    = 16'h0014;
    localparam logic [15:0] PCT_FULL     = 16'h0064;
endpackage
`default_nettype wire

// File: design/terminal_register_comm_status.sv
// Process-image exchange, status byte and parameter register bank
//
// Summary of operation
// [R1] Process data mode: status bit 7 reads zero.
// [R2] Status bit 6 set while a load short circuit is detected.
// [R3] Overtemperature sets bit 5 and clamps power to 20 percent.
// [R4] Status bit 4 set while overload is detected.
// [R5] Bits 3..1 report control mode; 0 full-wave, 1 mixed.
// [R6] Bit 0 set only when mains locked and no short circuit.
// [R7] Controller sets control bit 7 to request register access.
// [R8] Control bit 6 is direction, bits 5..0 the register index.
// [R9] Read returns register on input word; write takes output word.
// [R10] Handled register access answers with status bit 7 set.
// [R11] Register status echoes index in bits 5..0, direction in 6.
// [R12] Indices 0..63; reserved read zero, descriptors fixed.
// [R13] Timeout substitute values default to 0x3FFF and zero.
// [R14] Short-circuit policy register defaults to 0x0001.
// [R15] Control bit 7 clear: output word sets power 0..32767.
// [R16] User register writes need unlock code; unlock cleared on reset.
// [R17] Controller holds request until status echoes it.
// [R18] Writes to read-only or reserved indices ignored yet acknowledged.
`timescale 1ns/1ps
`default_nettype none
module terminal_register_comm_status #(
    parameter logic [15:0] KIND_ID    = 16'h00A5, // Arbitrary value
    parameter logic [15:0] FW_REV     = 16'h3141, // Firmware text code
    parameter logic [15:0] VARIANT_ID = 16'h005A, // Arbitrary value
    parameter logic [15:0] HW_REV     = 16'h0000, // Hardware revision
    parameter logic [15:0] MAINS_DEF  = 16'h0000  // Mains frequency default
) (
    input  wire logic        clock,          // 40 MHz system clock
    input  wire logic        srst,           // Sync reset, active high
    input  wire logic        cycle_strobe,   // Bus cycle exchange, one pulse
    input  wire logic [7:0]  control_octet,  // Control byte from controller
    input  wire logic [15:0] output_word,    // Data word from controller
    input  wire logic        short_pin,      // Load short circuit, async
    input  wire logic        hot_pin,        // Over 80 C comparator, async
    input  wire logic        cool_pin,       // Below 60 C comparator, async
    input  wire logic        overload_pin,   // Overload detect, async
    input  wire logic        mains_lock_pin, // Mains lock detect, async
    output logic      [7:0]  status_octet,   // Status byte to controller
    output logic      [15:0] input_word,     // Data word to controller
    output logic      [15:0] applied_power,  // Clamped power value
    output logic      [15:0] timeout_on_val, // Substitute value, load on
    output logic      [15:0] timeout_off_val,// Substitute value, load off
    output logic      [15:0] sc_policy,      // Short-circuit recovery policy
    output logic      [2:0]  control_mode    // Active control mode
);
    // Elaboration check: only the 50 Hz and 60 Hz codes exist
    if (MAINS_DEF > 16'h0001) begin : g_mains_check
        $error("MAINS_DEF must be 0 or 1");
    end
    // ==========================================================
    // Pin synchronisers
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    always_ff @(posedge clock) begin
        if (srst) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
        end else begin
            sync1_r <= {short_pin, hot_pin, cool_pin, overload_pin, mains_lock_pin};
            sync2_r <= sync1_r;
        end
    end
    logic s_short;
    logic s_hot;
    logic s_cool;
    logic s_ovl;
    logic s_lock;
    assign s_short = sync2_r[4];
    assign s_hot   = sync2_r[3];
    assign s_cool  = sync2_r[2];
    assign s_ovl   = sync2_r[1];
    assign s_lock  = sync2_r[0];
    // ==========================================================
    // Temperature warning with hysteresis between 80 C and 60 C
    logic warn_r;
    logic warn_nxt;
    always_comb begin
        warn_nxt = warn_r;
        if (s_hot) begin
            warn_nxt = 1'b1; // R3
        end else if (s_cool) begin
            warn_nxt = 1'b0; // R3
        end
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            warn_r <= 1'b0;
        end else begin
            warn_r <= warn_nxt;
        end
    end
    // ==========================================================
    // Register storage, addressed by index
    logic [15:0] regs_r   [64];
    logic [15:0] regs_nxt [64];
    logic        unlock_r;
    logic        unlock_nxt;
    // Writable indices; command and code word are always open
    function automatic logic is_rw(input logic [5:0] idx);
        case (idx)
            term_pkg::IDX_COMMAND, term_pkg::IDX_ALIGN, term_pkg::IDX_HWREV,
            term_pkg::IDX_UNLOCK, term_pkg::IDX_FEATURE, term_pkg::IDX_UOFFSET,
            term_pkg::IDX_UGAIN, term_pkg::IDX_FBTMO, term_pkg::IDX_TMO_ON,
            term_pkg::IDX_TMO_OFF, term_pkg::IDX_DRVMODE, term_pkg::IDX_SCPOL,
            term_pkg::IDX_MAINS: is_rw = 1'b1;
            default: is_rw = 1'b0;
        endcase
    endfunction
    // Reset or factory value; fixed descriptors also read through this
    function automatic logic [15:0] init_val(input logic [5:0] idx);
        case (idx)
            term_pkg::IDX_KIND:     init_val = KIND_ID;
            term_pkg::IDX_FWREV:    init_val = FW_REV;
            term_pkg::IDX_MUXSHIFT: init_val = term_pkg::VAL_MUXSHIFT;
            term_pkg::IDX_SIGCHAN:  init_val = term_pkg::VAL_SIGCHAN;
            term_pkg::IDX_MINLEN:   init_val = term_pkg::VAL_MINLEN;
            term_pkg::IDX_DSTRUCT:  init_val = term_pkg::VAL_DSTRUCT;
            term_pkg::IDX_ALIGN:    init_val = term_pkg::RST_ALIGN;
            term_pkg::IDX_HWREV:    init_val = HW_REV;
            term_pkg::IDX_VARIANT:  init_val = VARIANT_ID;
            term_pkg::IDX_UGAIN:    init_val = term_pkg::RST_UGAIN;
            term_pkg::IDX_FBTMO:    init_val = term_pkg::RST_FBTMO;
            term_pkg::IDX_TMO_ON:   init_val = term_pkg::RST_TMO_ON; // R13
            term_pkg::IDX_SCPOL:    init_val = term_pkg::RST_SCPOL;  // R14
            term_pkg::IDX_MAINS:    init_val = MAINS_DEF;
            default:                init_val = term_pkg::RST_ZERO;  // R12
        endcase
    endfunction
    // Indices restored by the factory-default command
    function automatic logic is_factory(input logic [5:0] idx);
        is_factory = (idx >= term_pkg::IDX_UOFFSET) && (idx <= term_pkg::IDX_MAINS);
    endfunction
    logic [5:0] req_idx;
    logic       req_wr;
    logic       reg_mode;
    assign req_idx  = control_octet[term_pkg::IDX_MSB:0]; // R8
    assign req_wr   = control_octet[term_pkg::DIR_BIT];   // R8
    assign reg_mode = control_octet[term_pkg::MODE_BIT];  // R7
    logic do_write;
    logic open_idx;
    assign open_idx = (req_idx == term_pkg::IDX_UNLOCK) || (req_idx == term_pkg::IDX_COMMAND);
    // Protected writes need the code word; descriptors never change
    assign do_write = cycle_strobe && reg_mode && req_wr && is_rw(req_idx)
                      && (unlock_r || open_idx); // R16 R18
    logic factory_go;
    assign factory_go = do_write && (req_idx == term_pkg::IDX_COMMAND)
                        && (output_word == term_pkg::CMD_FACTORY) && unlock_r;
    // Next register values
    always_comb begin
        unlock_nxt = unlock_r;
        if (do_write && req_idx == term_pkg::IDX_UNLOCK) begin
            unlock_nxt = (output_word == term_pkg::UNLOCK_CODE); // R16
        end
        for (int i = 0; i < 64; i++) begin
            regs_nxt[i] = regs_r[i];
            if (factory_go && is_factory(6'(i))) begin
                regs_nxt[i] = init_val(6'(i));
            end
        end
        if (do_write && !factory_go) begin
            regs_nxt[req_idx] = output_word; // R9
        end
    end
    // Descriptor slots are read from constants, yet storage holds all 64 slots, reset through init_val
    always_ff @(posedge clock) begin
        if (srst) begin
            unlock_r <= 1'b0; // R16
            for (int i = 0; i < 64; i++) begin
                regs_r[i] <= init_val(6'(i));
            end
        end else begin
            unlock_r <= unlock_nxt;
            for (int i = 0; i < 64; i++) begin
                regs_r[i] <= regs_nxt[i];
            end
        end
    end
    // ==========================================================
    // Process-image answer
    logic [7:0]  stat_r;
    logic [7:0]  stat_nxt;
    logic [15:0] inw_r;
    logic [15:0] inw_nxt;
    logic [15:0] read_val;
    logic [2:0]  mode_field;
    assign read_val   = is_rw(req_idx) ? regs_r[req_idx] : init_val(req_idx); // R12
    assign mode_field = regs_r[term_pkg::IDX_DRVMODE][2:0];
    always_comb begin
        stat_nxt = stat_r;
        inw_nxt  = inw_r;
        if (reg_mode) begin
            if (cycle_strobe) begin
                // Answer reflects the access as handled this cycle
                stat_nxt = {1'b1, req_wr, req_idx}; // R10 R11
                inw_nxt  = read_val;                 // R9
            end
        end else begin
            stat_nxt                   = 8'h00;
            stat_nxt[term_pkg::MODE_BIT] = 1'b0;     // R1
            stat_nxt[term_pkg::ERR_BIT]  = s_short;  // R2
            stat_nxt[term_pkg::TEMP_BIT] = warn_r;   // R3
            stat_nxt[term_pkg::OVL_BIT]  = s_ovl;    // R4
            stat_nxt[term_pkg::OPM_MSB:term_pkg::OPM_LSB] = mode_field; // R5
            stat_nxt[term_pkg::SYNC_BIT] = s_lock && !s_short;          // R6
            inw_nxt = applied_power;
        end
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            stat_r <= 8'h00;
            inw_r  <= term_pkg::RST_ZERO;
        end else begin
            stat_r <= stat_nxt;
            inw_r  <= inw_nxt;
        end
    end
    // ==========================================================
    // Parameter outputs, registered copies of storage
    logic [15:0] ton_r;
    logic [15:0] toff_r;
    logic [15:0] scp_r;
    logic [2:0]  mode_r;
    always_ff @(posedge clock) begin
        if (srst) begin
            ton_r  <= term_pkg::RST_TMO_ON;
            toff_r <= term_pkg::RST_ZERO;
            scp_r  <= term_pkg::RST_SCPOL;
            mode_r <= 3'h0;
        end else begin
            ton_r  <= regs_r[term_pkg::IDX_TMO_ON];  // R13
            toff_r <= regs_r[term_pkg::IDX_TMO_OFF]; // R13
            scp_r  <= regs_r[term_pkg::IDX_SCPOL];   // R14
            mode_r <= mode_field;
        end
    end
    // Power demand loads on process-data exchanges only; the clamp follows warn_r every cycle
    power_clamp u_clamp (
        .clock   (clock),
        .srst    (srst),
        .load_en (cycle_strobe && !reg_mode), // R15
        .demand  (output_word),
        .hot     (warn_r),
        .power   (applied_power)
    );
    assign status_octet    = stat_r;
    assign input_word      = inw_r;
    assign timeout_on_val  = ton_r;
    assign timeout_off_val = toff_r;
    assign sc_policy       = scp_r;
    assign control_mode    = mode_r;
endmodule
`default_nettype wire

// File: verif/coupler_model.sv
// Controller-side model issuing process-image exchanges
`timescale 1ns/1ps
`default_nettype none
module coupler_model (
    input  wire logic        clock,         // System clock
    output logic             cycle_strobe,  // Exchange pulse
    output logic      [7:0]  control_octet, // Control byte
    output logic      [15:0] output_word,   // Data to device
    input  wire logic [7:0]  status_octet,  // Status byte
    input  wire logic [15:0] input_word     // Data from device
);
    // ==========================================================
    // Idle at time zero: no exchange, process mode
    initial begin
        cycle_strobe = 1'b0;
        control_octet = 8'h00;
        output_word = 16'h0000;
    end
    // One exchange; a register request is held until echoed
    task automatic xfer(input logic [7:0] c, input logic [15:0] w,
                        output logic [15:0] rd, output logic ok);
        int n;
        n = 0;
        @(negedge clock);
        cycle_strobe <= 1'b1;
        control_octet <= c;
        output_word <= w;
        @(negedge clock);
        cycle_strobe <= 1'b0;
        if (c[7]) begin
            while (status_octet !== {1'b1, c[6:0]} && n < 8) begin
                @(negedge clock);
                n++;
            end
        end else begin
            repeat (3) @(negedge clock);
        end
        ok = (n < 8);
        rd = input_word;
        // Released word must not keep showing the written data
        if (c[7]) output_word <= ~w;
    endtask
endmodule
`default_nettype wire

// File: verif/term_checker.sv
// Concurrent checks on the terminal process-image block ports
`timescale 1ns/1ps
`default_nettype none
module term_checker (
    input wire logic        clock,          // System clock
    input wire logic        srst,           // Sync reset
    input wire logic        cycle_strobe,   // Exchange pulse
    input wire logic [7:0]  control_octet,  // Control byte
    input wire logic        short_pin,      // Load short
    input wire logic        hot_pin,        // Over temperature
    input wire logic        overload_pin,   // Overload
    input wire logic [7:0]  status_octet,   // Status byte
    input wire logic [15:0] input_word,     // Data to controller
    input wire logic [15:0] applied_power,  // Power value
    input wire logic [15:0] timeout_on_val, // Load-on value
    input wire logic [15:0] sc_policy,      // Short policy
    input wire logic [2:0]  control_mode    // Active mode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // ==========================================================
    // Register handshake
    property p_echo; cycle_strobe && control_octet[7] |=>
        status_octet == {1'b1, $past(control_octet[6:0])}; endproperty
    a_echo: assert property (p_echo) else $error("register echo wrong");
    property p_fixed; cycle_strobe && control_octet == 8'h8D |=> input_word == 16'h0004;
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed register wrong");
    property p_rstval; $fell(srst) |-> timeout_on_val == 16'h3FFF && sc_policy == 16'h0001;
    endproperty
    a_rstval: assert property (p_rstval) else $error("reset value wrong");
    // ==========================================================
    // Process data status; pins pass two sync stages first
    property p_pack; !control_octet[7] [*2] |=> !status_octet[7]; endproperty
    a_pack: assert property (p_pack) else $error("process ack wrong");
    property p_sync; !status_octet[7] |-> !(status_octet[0] && status_octet[6]); endproperty
    a_sync: assert property (p_sync) else $error("sync bit wrong");
    property p_short; (short_pin && !control_octet[7]) [*5] |-> status_octet[6]; endproperty
    a_short: assert property (p_short) else $error("short bit wrong");
    property p_ovl; (overload_pin && !control_octet[7]) [*5] |-> status_octet[4]; endproperty
    a_ovl: assert property (p_ovl) else $error("overload bit wrong");
    property p_mode; ($stable(control_mode) && !control_octet[7]) [*4] |->
        status_octet[3:1] == control_mode; endproperty
    a_mode: assert property (p_mode) else $error("mode field wrong");
    // ==========================================================
    // Power limits; clamp is 20 percent of full scale
    property p_pmax; applied_power <= 16'h7FFF; endproperty
    a_pmax: assert property (p_pmax) else $error("power above range");
    property p_clamp; hot_pin [*4] ##0 (cycle_strobe && !control_octet[7]) |->
        ##2 applied_power <= 16'h1999; endproperty
    a_clamp: assert property (p_clamp) else $error("power not clamped");
    c_write: cover property (cycle_strobe && control_octet[7] && control_octet[6]);
    c_proc: cover property (cycle_strobe && !control_octet[7]);
    c_hot: cover property (status_octet[5]);
endmodule
bind terminal_register_comm_status term_checker u_chk (.clock(clock), .srst(srst),
    .cycle_strobe(cycle_strobe), .control_octet(control_octet), .short_pin(short_pin),
    .hot_pin(hot_pin), .overload_pin(overload_pin), .status_octet(status_octet),
    .input_word(input_word), .applied_power(applied_power), .timeout_on_val(timeout_on_val),
    .sc_policy(sc_policy), .control_mode(control_mode));
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the terminal process-image block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clock, srst, cycle_strobe, ack;
    logic        short_pin, hot_pin, cool_pin, overload_pin, mains_lock_pin;
    logic [7:0]  control_octet, status_octet;
    logic [15:0] output_word, input_word, applied_power, rd_data;
    logic [15:0] timeout_on_val, timeout_off_val, sc_policy;
    logic [2:0]  control_mode;
    int          failures, total_checks;
    localparam logic [15:0] KIND = 16'h00C3; // Arbitrary value
    localparam logic [5:0]  DIX [22] = '{6'h00, 6'h07, 6'h08, 6'h0A, 6'h0B, 6'h0C, 6'h0D,
        6'h0E, 6'h0F, 6'h1F, 6'h20, 6'h21, 6'h22, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h3F,
        6'h09, 6'h10, 6'h29};
    localparam logic [15:0] DVAL [22] = '{16'h0000, 16'h0000, KIND, 16'h0118, 16'h0118,
        16'h9800, 16'h0004, 16'h0000, 16'h7F80, 16'h0000, 16'h0000, 16'h0000, 16'h0100,
        16'h000A, 16'h3FFF, 16'h0000, 16'h0000, 16'h0001, 16'h0000,
        16'h3141, 16'h0000, 16'h0000};
    // ==========================================================
    // Clock, device and controller model
    initial clock = 1'b0;
    always #12.5 clock = ~clock;
    terminal_register_comm_status #(.KIND_ID(KIND)) u_dut (.clock(clock), .srst(srst),
        .cycle_strobe(cycle_strobe), .control_octet(control_octet), .output_word(output_word),
        .short_pin(short_pin), .hot_pin(hot_pin), .cool_pin(cool_pin),
        .overload_pin(overload_pin), .mains_lock_pin(mains_lock_pin),
        .status_octet(status_octet), .input_word(input_word), .applied_power(applied_power),
        .timeout_on_val(timeout_on_val), .timeout_off_val(timeout_off_val),
        .sc_policy(sc_policy), .control_mode(control_mode));
    coupler_model u_cpl (.clock(clock), .cycle_strobe(cycle_strobe),
        .control_octet(control_octet), .output_word(output_word),
        .status_octet(status_octet), .input_word(input_word));
    // ==========================================================
    // Shared helpers
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("failures %0d total_checks %0d", failures, total_checks);
        if (failures == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic reg_rd(input logic [5:0] ix, input logic [15:0] exp);
        u_cpl.xfer({2'b10, ix}, 16'h0000, rd_data, ack);
        chk("read ack", {15'h0000, ack}, 16'h0001);
        chk("read data", rd_data, exp);
    endtask
    task automatic reg_wr(input logic [5:0] ix, input logic [15:0] v);
        u_cpl.xfer({2'b11, ix}, v, rd_data, ack);
        chk("write ack", {15'h0000, ack}, 16'h0001);
    endtask
    task automatic proc(input logic [15:0] demand, input int settle);
        repeat (settle) @(negedge clock);
        u_cpl.xfer(8'h00, demand, rd_data, ack);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_defaults();
        for (int i = 0; i < 22; i++) reg_rd(DIX[i], DVAL[i]);
        chk("on value", timeout_on_val, 16'h3FFF);
        chk("policy", sc_policy, 16'h0001);
    endtask
    task automatic t_proc();
        proc(16'h1000, 0);
        chk("power", applied_power, 16'h1000);
        chk("power word", rd_data, 16'h1000);
        chk("status", {8'h00, status_octet}, 16'h0001);
        proc(16'hFFFF, 0);
        chk("power limit", applied_power, 16'h7FFF);
    endtask
    task automatic t_pins();
        logic [2:0] pv [4] = '{3'b101, 3'b011, 3'b000, 3'b001};
        logic [7:0] sv [4] = '{8'h40, 8'h11, 8'h00, 8'h01};
        for (int i = 0; i < 4; i++) begin
            {short_pin, overload_pin, mains_lock_pin} <= pv[i];
            repeat (5) @(negedge clock);
            chk("pin status", {8'h00, status_octet}, {8'h00, sv[i]});
        end
    endtask
    // Clamp must survive the gap between the two thresholds
    task automatic t_hot();
        hot_pin <= 1'b1;
        cool_pin <= 1'b0;
        proc(16'h7FFF, 4);
        chk("hot power", applied_power, 16'h1999);
        chk("hot flag", {15'h0000, status_octet[5]}, 16'h0001);
        hot_pin <= 1'b0;
        proc(16'h7FFF, 4);
        chk("held clamp", applied_power, 16'h1999);
        cool_pin <= 1'b1;
        proc(16'h7FFF, 4);
        chk("released", applied_power, 16'h7FFF);
        chk("cool flag", {15'h0000, status_octet[5]}, 16'h0000);
    endtask
    task automatic t_lock();
        reg_wr(6'h25, 16'h1234);
        reg_rd(6'h25, 16'h3FFF);
        reg_wr(6'h1F, 16'h1235);
        reg_wr(6'h0A, 16'hFFFF);
        reg_rd(6'h0A, 16'h0118);
        reg_wr(6'h25, 16'h1234);
        reg_wr(6'h27, 16'h0001);
        reg_rd(6'h25, 16'h1234);
        reg_wr(6'h1F, 16'h0000);
        reg_wr(6'h26, 16'h5555);
        reg_rd(6'h26, 16'h0000);
        proc(16'h0000, 0);
        chk("mode field", {13'h0000, status_octet[3:1]}, 16'h0001);
        chk("on value", timeout_on_val, 16'h1234);
        chk("off value", timeout_off_val, 16'h0000);
        chk("mode out", {13'h0000, control_mode}, 16'h0001);
        reg_wr(6'h1F, 16'h1235);
        // Factory command restores defaults, command slot itself stays clear
        reg_wr(6'h07, 16'h7000);
        reg_rd(6'h25, 16'h3FFF);
        reg_rd(6'h27, 16'h0000);
        reg_rd(6'h07, 16'h0000);
        srst <= 1'b1;
        repeat (2) @(negedge clock);
        srst <= 1'b0;
        reg_wr(6'h25, 16'h7777);
        reg_rd(6'h25, 16'h3FFF);
    endtask
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        failures = 0;
        total_checks = 0;
        srst = 1'b1;
        {short_pin, hot_pin, overload_pin} = 3'b000;
        {cool_pin, mains_lock_pin} = 2'b11;
        repeat (2) @(negedge clock);
        srst <= 1'b0;
        t_defaults();
        t_proc();
        t_pins();
        t_hot();
        t_lock();
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
